// ---- src/board_test_defines.vh ----
`ifndef BOARD_TEST_DEFINES_VH
`define BOARD_TEST_DEFINES_VH

// ----------------------------------------
// test codes on the four code inputs
// ----------------------------------------
`define TCODE_NAND_CHAIN 4'hA
`define TCODE_PIN_FLOAT 4'hC
`define TCODE_OUT_HIGH 4'hE
`define TCODE_OUT_LOW 4'hF

// ----------------------------------------
// checksum colour select encodings
// ----------------------------------------
`define CSEL_RED 2'h0
`define CSEL_GREEN 2'h1
`define CSEL_BLUE 2'h2

// ----------------------------------------
// checksum states and widths
// ----------------------------------------
`define CK_IDLE 2'h0
`define CK_ARMED 2'h1
`define CK_RUN 2'h2
`define CK_DONE 2'h3
`define CK_WIDTH 16
`define CK_RESET 16'h0000
`define CK_POLY 16'h1021

`endif

// ---- src/pixel_checksum.v ----
`include "board_test_defines.vh"

module pixel_checksum #(
    parameter COMP_WIDTH = 10
) (
    input wire sys_clk,
    input wire reset_n,
    input wire [2*COMP_WIDTH+COMP_WIDTH-1:0] dac_pixel,
    input wire display_active,
    input wire frame_start,
    input wire [1:0] colour_sel,
    input wire start_measure,
    output wire measure_busy,
    output wire result_valid,
    output wire [`CK_WIDTH-1:0] checksum_out
);

    // ----------------------------------------
    // state
    // ----------------------------------------
    reg [1:0] state_reg; // measurement sequencer
    reg [1:0] state_next;
    reg [`CK_WIDTH-1:0] acc_reg; // running crc
    reg [`CK_WIDTH-1:0] acc_next;
    reg [`CK_WIDTH-1:0] result_reg; // frozen result
    reg [`CK_WIDTH-1:0] result_next;
    reg [1:0] sel_reg; // colour latched at start
    reg [1:0] sel_next;
    reg [COMP_WIDTH-1:0] comp; // chosen component
    reg [`CK_WIDTH-1:0] crc_v;
    integer i;

    // ----------------------------------------
    // component pick, dac input bus is r,g,b
    // ----------------------------------------
    always @* begin
        case (sel_reg) // [R14]
            `CSEL_RED: comp = dac_pixel[3*COMP_WIDTH-1:2*COMP_WIDTH];
            `CSEL_GREEN: comp = dac_pixel[2*COMP_WIDTH-1:COMP_WIDTH];
            default: comp = dac_pixel[COMP_WIDTH-1:0];
        endcase
    end

    // ----------------------------------------
    // crc step, one component per pixel clock
    // ----------------------------------------
    always @* begin
        crc_v = acc_reg;
        for (i = COMP_WIDTH - 1; i >= 0; i = i - 1) begin // [R13] [R19]
            if (crc_v[`CK_WIDTH-1] ^ comp[i]) begin
                crc_v = {crc_v[`CK_WIDTH-2:0], 1'b0} ^ `CK_POLY;
            end else begin
                crc_v = {crc_v[`CK_WIDTH-2:0], 1'b0};
            end
        end
    end

    // ----------------------------------------
    // sequencer: wait for frame, run one frame
    // ----------------------------------------
    always @* begin
        state_next = state_reg;
        acc_next = acc_reg;
        result_next = result_reg;
        sel_next = sel_reg;
        case (state_reg)
            `CK_IDLE, `CK_DONE: begin
                if (start_measure) begin
                    acc_next = `CK_RESET; // [R19]
                    sel_next = colour_sel; // [R14]
                    state_next = `CK_ARMED;
                end
            end
            `CK_ARMED: begin
                // whole frames only, so partial frames never mix in
                if (frame_start) begin
                    state_next = `CK_RUN;
                end
            end
            `CK_RUN: begin
                if (frame_start) begin
                    result_next = acc_reg; // [R19]
                    state_next = `CK_DONE;
                end else if (display_active) begin
                    // blanking and sync never reach the crc
                    acc_next = crc_v; // [R15] [R16] [R17]
                end
            end
            default: state_next = `CK_IDLE;
        endcase
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always @(posedge sys_clk) begin
        if (!reset_n) begin
            state_reg <= `CK_IDLE;
            acc_reg <= `CK_RESET;
            result_reg <= `CK_RESET;
            sel_reg <= `CSEL_RED;
        end else begin
            state_reg <= state_next;
            acc_reg <= acc_next;
            result_reg <= result_next;
            sel_reg <= sel_next;
        end
    end

    assign measure_busy = (state_reg == `CK_ARMED) || (state_reg == `CK_RUN);
    assign result_valid = (state_reg == `CK_DONE);
    assign checksum_out = result_reg;

endmodule

// ---- src/board_test_modes.v ----
// Behaviour
// R1 - select low: normal operation, pins normal
// R2 - select high: low address/data pins become code
// R3 - mode decoded combinationally, no clock
// R4 - code 1010 selects nand chain
// R5 - each input pad feeds nand stage
// R6 - first stage spare input tied high
// R7 - chain end drives chosen output pin
// R8 - output-only pins excluded from chain
// R9 - code 1100 tristates all outputs
// R10 - code 1110 drives all outputs high
// R11 - code 1111 drives all outputs low
// R12 - other codes leave outputs normal
// R13 - checksum sees dac inputs at pixel rate
// R14 - one selectable colour component at a time
// R15 - only active display pixels accumulate
// R16 - sync timing never affects checksum
// R17 - taken at dac inputs, no analogue
// R18 - software compares against reference value
// R19 - cleared at start, result held per frame
`include "board_test_defines.vh"

module board_test_modes #(
    parameter NUM_IN = 8,
    parameter NUM_OUT = 8,
    parameter NUM_BIDIR = 8,
    parameter MPAD_WIDTH = 8,
    parameter COMP_WIDTH = 10
) (
    input wire sys_clk,
    input wire reset_n,
    input wire test_select_pin,
    input wire [NUM_IN-1:0] in_pad,
    input wire [MPAD_WIDTH-1:0] multiport_addr_data_i,
    input wire [NUM_BIDIR-1:0] bidir_pad_i,
    input wire [NUM_OUT-1:0] core_out,
    input wire [MPAD_WIDTH-1:0] core_mpad_o,
    input wire [MPAD_WIDTH-1:0] core_mpad_oe_n,
    input wire [NUM_BIDIR-1:0] core_bidir_o,
    input wire [NUM_BIDIR-1:0] core_bidir_oe_n,
    output wire [NUM_IN-1:0] core_in,
    output wire [MPAD_WIDTH-1:0] core_mpad_i,
    output wire [NUM_BIDIR-1:0] core_bidir_i,
    output wire [NUM_OUT-1:0] out_pad_o,
    output wire [NUM_OUT-1:0] out_pad_oe_n,
    output wire [MPAD_WIDTH-1:0] multiport_addr_data_o,
    output wire [MPAD_WIDTH-1:0] multiport_addr_data_oe_n,
    output wire [NUM_BIDIR-1:0] bidir_pad_o,
    output wire [NUM_BIDIR-1:0] bidir_pad_oe_n,
    output wire [3:0] test_code_inputs,
    output wire test_active,
    input wire [3*COMP_WIDTH-1:0] dac_pixel,
    input wire display_active,
    input wire frame_start,
    input wire [1:0] colour_sel,
    input wire start_measure,
    output wire measure_busy,
    output wire result_valid,
    output wire [`CK_WIDTH-1:0] checksum_out
);

    // ----------------------------------------
    // chain geometry
    // ----------------------------------------
    // output-only pins never join the chain
    localparam CHAIN_LEN = NUM_IN + MPAD_WIDTH + NUM_BIDIR; // [R8]

    wire [CHAIN_LEN-1:0] chain_pads; // every input-capable pad
    wire [CHAIN_LEN:0] chain_node; // stage outputs
    wire mode_nand; // nand chain active
    wire mode_float; // all drivers off
    wire mode_high; // all drivers high
    wire mode_low; // all drivers low
    wire force_drive; // high or low override

    // ----------------------------------------
    // code inputs: pure gates, work without sys_clk
    // ----------------------------------------
    // gated to zero when not selected so no mode decodes by accident
    assign test_code_inputs = test_select_pin ? multiport_addr_data_i[3:0] : 4'h0; // [R2]
    assign test_active = test_select_pin;
    assign mode_nand = test_select_pin && (test_code_inputs == `TCODE_NAND_CHAIN); // [R3] [R4]
    assign mode_float = test_select_pin && (test_code_inputs == `TCODE_PIN_FLOAT); // [R3] [R9]
    assign mode_high = test_select_pin && (test_code_inputs == `TCODE_OUT_HIGH); // [R3] [R10]
    assign mode_low = test_select_pin && (test_code_inputs == `TCODE_OUT_LOW); // [R3] [R11]
    assign force_drive = mode_high || mode_low;

    // ----------------------------------------
    // nand chain through all input paths
    // ----------------------------------------
    assign chain_pads = {bidir_pad_i, multiport_addr_data_i, in_pad};
    assign chain_node[0] = 1'b1; // [R6]

    genvar g;
    generate
        for (g = 0; g < CHAIN_LEN; g = g + 1) begin : nand_stage
            // pad g meets the previous stage, first pad meets the tie-high
            assign chain_node[g+1] = ~(chain_node[g] & chain_pads[g]); // [R5] [R6]
        end
    endgenerate

    // ----------------------------------------
    // core-side inputs pass through untouched
    // ----------------------------------------
    // the core keeps seeing pins; test modes only override drivers
    assign core_in = in_pad; // [R1]
    assign core_mpad_i = multiport_addr_data_i; // [R1]
    assign core_bidir_i = bidir_pad_i; // [R1]

    // ----------------------------------------
    // output-only pins
    // ----------------------------------------
    // out_pad bit 0 carries the chain result in nand mode
    assign out_pad_o[0] = mode_nand ? chain_node[CHAIN_LEN] : // [R7]
                          mode_high ? 1'b1 : // [R10]
                          mode_low ? 1'b0 : // [R11]
                          core_out[0]; // [R1] [R12]
    assign out_pad_oe_n[0] = mode_nand ? 1'b0 : // [R7]
                             mode_float ? 1'b1 : // [R9]
                             force_drive ? 1'b0 : 1'b0;

    generate
        for (g = 1; g < NUM_OUT; g = g + 1) begin : out_only
            assign out_pad_o[g] = mode_high ? 1'b1 : // [R10]
                                  mode_low ? 1'b0 : // [R11]
                                  core_out[g]; // [R12]
            assign out_pad_oe_n[g] = mode_float ? 1'b1 : 1'b0; // [R9]
        end
    endgenerate

    // ----------------------------------------
    // multiport pins
    // ----------------------------------------
    // in nand mode these are chain inputs, so never driven;
    // in any test mode the low four carry the code and stay inputs
    generate
        for (g = 0; g < MPAD_WIDTH; g = g + 1) begin : mpad
            if (g < 4) begin : code_bit
                assign multiport_addr_data_o[g] = core_mpad_o[g];
                assign multiport_addr_data_oe_n[g] = test_select_pin ? 1'b1 : // [R2]
                                                     core_mpad_oe_n[g]; // [R1]
            end else begin : data_bit
                assign multiport_addr_data_o[g] = mode_high ? 1'b1 : // [R10]
                                                  mode_low ? 1'b0 : // [R11]
                                                  core_mpad_o[g]; // [R12]
                assign multiport_addr_data_oe_n[g] = (mode_float || mode_nand) ? 1'b1 : // [R9]
                                                     force_drive ? 1'b0 : // [R10] [R11]
                                                     core_mpad_oe_n[g]; // [R12]
            end
        end
    endgenerate

    // ----------------------------------------
    // other bidirectional pins
    // ----------------------------------------
    generate
        for (g = 0; g < NUM_BIDIR; g = g + 1) begin : bidir
            assign bidir_pad_o[g] = mode_high ? 1'b1 : // [R10]
                                    mode_low ? 1'b0 : // [R11]
                                    core_bidir_o[g]; // [R1] [R12]
            assign bidir_pad_oe_n[g] = (mode_float || mode_nand) ? 1'b1 : // [R9] [R5]
                                       force_drive ? 1'b0 : // [R10] [R11]
                                       core_bidir_oe_n[g]; // [R12]
        end
    endgenerate

    // ----------------------------------------
    // checksum on the pixel clock
    // ----------------------------------------
    // software compares checksum_out with its reference [R18]
    pixel_checksum #(
        .COMP_WIDTH(COMP_WIDTH)
    ) u_checksum (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .dac_pixel(dac_pixel),
        .display_active(display_active),
        .frame_start(frame_start),
        .colour_sel(colour_sel),
        .start_measure(start_measure),
        .measure_busy(measure_busy),
        .result_valid(result_valid),
        .checksum_out(checksum_out)
    );

endmodule

// ---- sim/board_test_modes_props.sv ----
`include "board_test_defines.vh"
// ----------------------------------------
// port checks for the board test block
// ----------------------------------------
module board_test_modes_props #(
    parameter NUM_IN = 8,
    parameter NUM_OUT = 8,
    parameter NUM_BIDIR = 8,
    parameter MPAD_WIDTH = 8
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic test_select_pin,
    input wire logic [NUM_IN-1:0] in_pad,
    input wire logic [MPAD_WIDTH-1:0] multiport_addr_data_i,
    input wire logic [NUM_BIDIR-1:0] bidir_pad_i,
    input wire logic [NUM_OUT-1:0] core_out,
    input wire logic [NUM_BIDIR-1:0] core_bidir_oe_n,
    input wire logic [NUM_OUT-1:0] out_pad_o,
    input wire logic [NUM_OUT-1:0] out_pad_oe_n,
    input wire logic [NUM_BIDIR-1:0] bidir_pad_o,
    input wire logic [NUM_BIDIR-1:0] bidir_pad_oe_n,
    input wire logic [3:0] test_code_inputs,
    input wire logic frame_start,
    input wire logic start_measure,
    input wire logic measure_busy,
    input wire logic result_valid,
    input wire logic [`CK_WIDTH-1:0] checksum_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // pads in chain order: inputs, mpad, bidir
    wire [NUM_IN+MPAD_WIDTH+NUM_BIDIR-1:0] pads = {bidir_pad_i, multiport_addr_data_i, in_pad};
    // zero when select is low, and zero is no test code
    wire [3:0] code = test_select_pin ? multiport_addr_data_i[3:0] : 4'h0;
    logic chain_bit;  // expected chain end

    // ripple from a first stage whose spare input sits high
    always_comb begin
        chain_bit = 1'b1;
        for (int k = 0; k < $bits(pads); k++)
            chain_bit = ~(chain_bit & pads[k]);
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    a_code_pins_map: assert property (test_code_inputs == code)
        else $error("test code wrong");
    a_normal_pins_kept: assert property (!test_select_pin |-> out_pad_o == core_out
        && bidir_pad_oe_n == core_bidir_oe_n) else $error("normal pins changed");
    a_float_all_off: assert property (code == `TCODE_PIN_FLOAT |->
        &{out_pad_oe_n, bidir_pad_oe_n}) else $error("driver not floated");
    a_high_all_on: assert property (code == `TCODE_OUT_HIGH |-> &{out_pad_o, bidir_pad_o}
        && !(|{out_pad_oe_n, bidir_pad_oe_n})) else $error("not all high");
    a_low_all_on: assert property (code == `TCODE_OUT_LOW |->
        !(|{out_pad_o, bidir_pad_o, out_pad_oe_n, bidir_pad_oe_n})) else $error("not all low");
    a_chain_end_out: assert property (code == `TCODE_NAND_CHAIN |->
        out_pad_o[0] == chain_bit && !out_pad_oe_n[0]) else $error("chain output wrong");
    a_other_code_normal: assert property (test_select_pin && !(code inside {`TCODE_NAND_CHAIN,
        `TCODE_PIN_FLOAT, `TCODE_OUT_HIGH, `TCODE_OUT_LOW}) |-> out_pad_o == core_out)
        else $error("unlisted code overrode pins");
    a_start_arms_busy: assert property (start_measure && !measure_busy |=>
        measure_busy && !result_valid) else $error("start not taken");
    a_busy_ends_frame: assert property ($fell(measure_busy) |->
        $past(frame_start) && result_valid) else $error("result not at frame edge");
    a_result_held: assert property (result_valid && $past(result_valid) |->
        $stable(checksum_out)) else $error("result moved");
endmodule

bind board_test_modes board_test_modes_props #(.NUM_IN(NUM_IN), .NUM_OUT(NUM_OUT),
    .NUM_BIDIR(NUM_BIDIR), .MPAD_WIDTH(MPAD_WIDTH)) u_board_test_modes_props (.*);

// ---- sim/frame_source.sv ----
// ----------------------------------------
// video source at the dac inputs
// ----------------------------------------
module frame_source (
    input wire logic sys_clk,
    input wire logic run,
    input wire logic [3:0] blank_len,
    input wire logic [29:0] seed,
    output logic frame_start,
    output logic display_active,
    output logic [29:0] dac_pixel
);
    timeunit 1ns;
    timeprecision 1ps;
    int pos = 0;  // cycle in frame, 0 is the boundary
    int col;  // place in the current line
    logic [29:0] pat;  // reseeded each frame so frames repeat
    logic [29:0] pix = 30'h0;  // last value put out
    assign col = (pos - 1) % (8 + blank_len);
    assign dac_pixel = pix;

    // three lines of eight pixels, each followed by blank_len blanked cycles
    always @(negedge sys_clk) begin
        frame_start <= run && pos == 0;
        display_active <= run && pos != 0 && col < 8;
        if (run && pos == 0)
            pat <= seed;
        if (run && pos != 0 && col < 8) begin
            pix <= pat;
            pat <= {pat[28:0], pat[29] ^ pat[5]};
        end else
            pix <= ~pix;  // blanked or idle: junk that moves every cycle
        pos <= (!run || pos == 3 * (8 + blank_len)) ? 0 : pos + 1;
    end
endmodule

// ---- sim/tb_board_test_modes.sv ----
`include "board_test_defines.vh"
module tb_board_test_modes;
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic sys_clk, reset_n, test_select_pin, start_measure, run;
    logic [7:0] in_pad, multiport_addr_data_i, bidir_pad_i, core_out, core_mpad_o;
    logic [7:0] core_mpad_oe_n, core_bidir_o, core_bidir_oe_n;
    logic [1:0] colour_sel, comp_sel;
    logic [3:0] blank_len = 4'h0;
    logic [29:0] seed = 30'h1;
    logic [31:0] rnd = 32'h0000004B;  // lfsr state
    logic [15:0] exp_crc;
    logic [3:0] tcode;  // code the pads should decode this cycle
    int fs_seen = 0, bad_count = 0, checks_done = 0;
    wire [7:0] core_in, core_mpad_i, core_bidir_i, out_pad_o, out_pad_oe_n;
    wire [7:0] multiport_addr_data_o, multiport_addr_data_oe_n, bidir_pad_o, bidir_pad_oe_n;
    wire [3:0] test_code_inputs;
    wire test_active, measure_busy, result_valid, display_active, frame_start;
    wire [15:0] checksum_out;
    wire [29:0] dac_pixel;
    wire [23:0] pads = {bidir_pad_i, multiport_addr_data_i, in_pad};

    board_test_modes u_board_test_modes (.*);
    frame_source u_frame_source (.*);

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    function automatic logic [31:0] next_rand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // crc of one component, msb first
    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [9:0] v);
        for (int i = 9; i >= 0; i--)
            c = (c[15] ^ v[i]) ? ((c << 1) ^ `CK_POLY) : (c << 1);
        return c;
    endfunction

    function automatic logic nand_end();
        logic n;
        n = 1'b1;
        for (int k = 0; k < 24; k++)
            n = ~(n & pads[k]);
        return n;
    endfunction

    // driver enables per mode: float and chain release, high and low force on
    function automatic logic [7:0] oe_exp(input logic [3:0] code, input logic [7:0] core_oe);
        if (code == `TCODE_PIN_FLOAT || code == `TCODE_NAND_CHAIN)
            return 8'hFF;
        if (code == `TCODE_OUT_HIGH || code == `TCODE_OUT_LOW)
            return 8'h00;
        return core_oe;
    endfunction

    // driven levels per mode, core value when no override applies
    function automatic logic [7:0] o_exp(input logic [3:0] code, input logic [7:0] core_o);
        if (code == `TCODE_OUT_HIGH)
            return 8'hFF;
        if (code == `TCODE_OUT_LOW)
            return 8'h00;
        return core_o;
    endfunction

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // reference crc over active pixels of the frame after arming
    // every start restarts the reference; the measurement restarts only on a start from idle or done
    always @(posedge sys_clk) begin
        if (start_measure) begin
            fs_seen <= 0;
            exp_crc <= `CK_RESET;
        end else if (frame_start)
            fs_seen <= fs_seen + 1;
        else if (fs_seen == 1 && display_active)
            exp_crc <= crc_step(exp_crc, comp_sel == 2'h0 ? dac_pixel[29:20] :
                comp_sel == 2'h1 ? dac_pixel[19:10] : dac_pixel[9:0]);
    end

    // start held two edges: the second, while busy, must be ignored
    task automatic measure(input logic [1:0] sel, input logic [3:0] blank);
        int n;
        comp_sel = sel;
        blank_len = blank;
        rnd = next_rand(rnd);
        seed = rnd[29:0] | 30'h1;
        colour_sel = sel;
        start_measure = 1'b1;
        @(negedge sys_clk);
        check("busy", 16'h1, measure_busy);
        colour_sel = ~sel;
        @(negedge sys_clk);
        start_measure = 1'b0;
        run <= 1'b1;
        n = 0;
        while (result_valid !== 1'b1 && n < 400) begin
            @(negedge sys_clk);
            n++;
        end
        run <= 1'b0;
        check("checksum", exp_crc, checksum_out);
        if (n == 400) begin
            bad_count++;
            summarize();
        end
    endtask

    initial begin
        reset_n = 1'b0;
        run = 1'b0;
        test_select_pin = 1'b0;
        start_measure = 1'b0;
        colour_sel = 2'h0;
        {in_pad, multiport_addr_data_i, bidir_pad_i, core_out} = 32'h0;
        {core_mpad_o, core_mpad_oe_n, core_bidir_o, core_bidir_oe_n} = 32'h0;
        repeat (3) @(negedge sys_clk);
        reset_n = 1'b1;
        check("valid", 16'h0, result_valid);
        for (int i = 0; i < 96; i++) begin
            @(negedge sys_clk);
            rnd = next_rand(rnd);
            {in_pad, bidir_pad_i, core_out, core_bidir_o} = rnd;
            rnd = next_rand(rnd);
            {core_mpad_o, core_mpad_oe_n, core_bidir_oe_n} = rnd[23:0];
            multiport_addr_data_i = {rnd[31:28], i[3:0]};
            test_select_pin = i[4];
            #1;
            check("code", test_select_pin ? i[3:0] : 4'h0, test_code_inputs);
            check("core_in", in_pad, core_in);
            tcode = test_select_pin ? i[3:0] : 4'h0;
            check("mpad_i", multiport_addr_data_i, core_mpad_i);
            check("bidir_i", bidir_pad_i, core_bidir_i);
            check("active", test_select_pin, test_active);
            check("bidir_oe", oe_exp(tcode, core_bidir_oe_n), bidir_pad_oe_n);
            check("bidir_o", o_exp(tcode, core_bidir_o), bidir_pad_o);
            check("out_oe", tcode == `TCODE_PIN_FLOAT ? 8'hFF : 8'h00, out_pad_oe_n);
            // code pins stay inputs in every test mode, only the upper four follow it
            check("mpad_oe", oe_exp(tcode, core_mpad_oe_n) | {4'h0, {4{test_select_pin}}},
                multiport_addr_data_oe_n);
            check("mpad_o", (o_exp(tcode, core_mpad_o) & 8'hF0) | (core_mpad_o & 8'h0F),
                multiport_addr_data_o);
            case (test_select_pin ? i[3:0] : 4'h0)
                `TCODE_PIN_FLOAT: check("float", 16'hFF, out_pad_oe_n);
                `TCODE_OUT_HIGH: check("high", 16'hFF, out_pad_o);
                `TCODE_OUT_LOW: check("low", 16'h0, out_pad_o);
                `TCODE_NAND_CHAIN: check("chain", nand_end(), out_pad_o[0]);
                default: check("normal", core_out, out_pad_o);
            endcase
        end
        test_select_pin = 1'b0;
        for (int c = 0; c < 4; c++) begin
            rnd = next_rand(rnd);
            measure(c[1:0], rnd[3:0]);
        end
        measure(2'h1, 4'h0);
        summarize();
    end
endmodule
